// ### core/pecl_classifier.sv
// Error detection, severity split and logging for the south bridge link port.
// Assumes error pulses come from link logic on the same clock; supply good is a pin.
`include "pecl_regs.svh"

module pecl_classifier #(
    parameter int unsigned ACK_WAIT_CYC = `PECL_ACK_WAIT_NS / `PECL_CLK_NS
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic dllp_proto_i,
    input wire logic msg_fatal_i,
    input wire logic unsup_req_i,
    input wire logic poisoned_i,
    input wire logic fc_proto_i,
    input wire logic cpl_timeout_i,
    input wire logic cpl_abort_i,
    input wire logic unexp_cpl_i,
    input wire logic malformed_i,
    input wire logic rx_overflow_i,
    input wire logic msg_nonfatal_i,
    input wire logic receiver_err_i,
    input wire logic bad_tlp_i,
    input wire logic bad_dllp_i,
    input wire logic replay_rollover_i,
    input wire logic replay_timeout_i,
    input wire logic msg_corr_i,
    input wire logic link_down_i,
    input wire logic [31:0] hdr_i,
    input wire logic supply_good_i,
    input wire logic hold_start_i,
    input wire logic reset_done_ack_i,
    output logic cpu_hold_o,
    output logic fatal_o,
    output logic nonfatal_o,
    output logic corr_o
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [12:0] unc_sts_q, unc_sev_q, fat_first_q, fat_next_q;
    logic [5:0] cor_sts_q;
    logic [18:0] nfc_first_q, nfc_next_q;
    logic [3:0] ptr_q;
    logic [2:0] rp_sts_q;
    logic [3:0] dev_sts_q;
    logic [31:0] hdr_first_q, hdr_next_q, rdata_q;
    logic hdr_first_vld_q;
    logic sg_s1_q, sg_s2_q, sg_s3_q, sg_q;
    logic tmo_q, cpu_hold_q;
    logic [31:0] wait_cnt_q;
    pecl_pkg::pecl_hold_state_t hold_st_q;
    logic fatal_q, nonfatal_q, corr_q;

    logic [12:0] unc_ev, sev_eff, fat_ev, nf_ev;
    logic [5:0] cor_ev;
    logic [18:0] nfc_ev;
    logic any_ev;
    logic [12:0] fat_first_kept, unc_kept;
    logic [18:0] nfc_first_kept;

    function automatic logic [31:0] clr_of(input logic [7:0] a);
        clr_of = (wr_i && addr_i == a) ? wdata_i : 32'h0000_0000;
    endfunction : clr_of

    function automatic logic [3:0] lowest(input logic [12:0] v);
        lowest = 4'h0;
        for (int i = 12; i >= 0; i--) begin
            if (v[i]) begin
                lowest = 4'(i);
            end
        end
    endfunction : lowest

    // ****************************************
    // Event classification
    // ****************************************
    assign unc_ev = {link_down_i,
                     tmo_q,
                     msg_nonfatal_i,
                     rx_overflow_i,
                     malformed_i,
                     unexp_cpl_i,
                     cpl_abort_i,
                     cpl_timeout_i,
                     fc_proto_i,
                     poisoned_i,
                     unsup_req_i,
                     msg_fatal_i,
                     dllp_proto_i};
    assign cor_ev = {msg_corr_i,
                     replay_timeout_i,
                     replay_rollover_i,
                     bad_dllp_i,
                     bad_tlp_i,
                     receiver_err_i};
    assign sev_eff = (unc_sev_q & `PECL_SEV_SEL_MASK) | `PECL_SEV_FIX_FATAL;
    assign fat_ev = unc_ev & sev_eff;
    assign nf_ev = unc_ev & ~sev_eff;
    assign nfc_ev = {cor_ev, nf_ev};
    assign any_ev = (|unc_ev) | (|cor_ev);
    always_comb begin
        fat_first_kept = fat_first_q & ~13'(clr_of(`PECL_ADDR_FAT_FIRST));
        nfc_first_kept = nfc_first_q & ~19'(clr_of(`PECL_ADDR_NFC_FIRST));
        unc_kept = unc_sts_q & ~13'(clr_of(`PECL_ADDR_UNC_STS));
    end

    // ****************************************
    // Supply good synchroniser
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sg_s1_q <= 1'b0;
            sg_s2_q <= 1'b0;
            sg_s3_q <= 1'b0;
            sg_q <= 1'b0;
        end else begin
            sg_s1_q <= supply_good_i;
            sg_s2_q <= sg_s1_q;
            sg_s3_q <= sg_s2_q;
            if (sg_s2_q == sg_s3_q) begin
                sg_q <= sg_s3_q;
            end
        end
    end

    // ****************************************
    // Processor hold and acknowledge wait
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hold_st_q <= pecl_pkg::PECL_HOLD_IDLE;
            cpu_hold_q <= 1'b0;
            wait_cnt_q <= 32'h0000_0000;
            tmo_q <= 1'b0;
        end else begin
            tmo_q <= 1'b0;
            case (hold_st_q)
                pecl_pkg::PECL_HOLD_IDLE: begin
                    wait_cnt_q <= 32'h0000_0000;
                    if (hold_start_i) begin
                        hold_st_q <= pecl_pkg::PECL_HOLD_WAIT;
                        cpu_hold_q <= 1'b1;
                    end
                end
                pecl_pkg::PECL_HOLD_WAIT: begin
                    if (reset_done_ack_i) begin
                        hold_st_q <= pecl_pkg::PECL_HOLD_IDLE;
                        cpu_hold_q <= 1'b0;
                    end else if (sg_q) begin
                        if (wait_cnt_q >= ACK_WAIT_CYC - 1) begin
                            hold_st_q <= pecl_pkg::PECL_HOLD_IDLE;
                            cpu_hold_q <= 1'b0;
                            tmo_q <= 1'b1;
                        end else begin
                            wait_cnt_q <= wait_cnt_q + 32'h0000_0001;
                        end
                    end
                end
                default: begin
                    hold_st_q <= pecl_pkg::PECL_HOLD_IDLE;
                    cpu_hold_q <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Status and severity registers
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            unc_sts_q <= 13'h0000;
            cor_sts_q <= 6'h00;
            unc_sev_q <= `PECL_SEV_RST;
            rp_sts_q <= 3'h0;
            dev_sts_q <= 4'h0;
        end else begin
            unc_sts_q <= unc_kept | unc_ev;
            cor_sts_q <= (cor_sts_q & ~6'(clr_of(`PECL_ADDR_COR_STS))) | cor_ev;
            if (wr_i && addr_i == `PECL_ADDR_UNC_SEV) begin
                unc_sev_q <= wdata_i[12:0];
            end
            rp_sts_q <= (rp_sts_q & ~3'(clr_of(`PECL_ADDR_RP_STS))) |
                        {msg_fatal_i, msg_nonfatal_i, msg_corr_i};
            dev_sts_q <= (dev_sts_q & ~4'(clr_of(`PECL_ADDR_DEV_STS))) |
                         {unsup_req_i, |fat_ev, |nf_ev, |cor_ev};
        end
    end

    // ****************************************
    // First error pointer
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ptr_q <= 4'h0;
        end else if (unc_kept == 13'h0000 && unc_ev != 13'h0000) begin
            ptr_q <= lowest(unc_ev);
        end
    end

    // ****************************************
    // First and next error logs
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fat_first_q <= 13'h0000;
            fat_next_q <= 13'h0000;
            nfc_first_q <= 19'h00000;
            nfc_next_q <= 19'h00000;
        end else begin
            if (fat_first_kept == 13'h0000) begin
                fat_first_q <= fat_ev;
                fat_next_q <= fat_next_q & ~13'(clr_of(`PECL_ADDR_FAT_NEXT));
            end else begin
                fat_first_q <= fat_first_kept;
                fat_next_q <= (fat_next_q & ~13'(clr_of(`PECL_ADDR_FAT_NEXT))) | fat_ev;
            end
            if (nfc_first_kept == 19'h00000) begin
                nfc_first_q <= nfc_ev;
                nfc_next_q <= nfc_next_q & ~19'(clr_of(`PECL_ADDR_NFC_NEXT));
            end else begin
                nfc_first_q <= nfc_first_kept;
                nfc_next_q <= (nfc_next_q & ~19'(clr_of(`PECL_ADDR_NFC_NEXT))) | nfc_ev;
            end
        end
    end

    // ****************************************
    // Header capture
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hdr_first_q <= 32'h0000_0000;
            hdr_next_q <= 32'h0000_0000;
            hdr_first_vld_q <= 1'b0;
        end else begin
            if (any_ev && (!hdr_first_vld_q || (wr_i && addr_i == `PECL_ADDR_HDR_FIRST))) begin
                hdr_first_q <= hdr_i;
                hdr_first_vld_q <= 1'b1;
            end else if (wr_i && addr_i == `PECL_ADDR_HDR_FIRST) begin
                hdr_first_vld_q <= 1'b0;
            end
            if (any_ev && hdr_first_vld_q) begin
                hdr_next_q <= hdr_i;
            end
        end
    end

    // ****************************************
    // Summary outputs
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fatal_q <= 1'b0;
            nonfatal_q <= 1'b0;
            corr_q <= 1'b0;
        end else begin
            fatal_q <= |fat_ev;
            nonfatal_q <= |nf_ev;
            corr_q <= |cor_ev;
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_i) begin
            case (addr_i)
                `PECL_ADDR_UNC_STS: rdata_q <= {19'h00000, unc_sts_q};
                `PECL_ADDR_UNC_SEV: rdata_q <= {19'h00000, unc_sev_q};
                `PECL_ADDR_COR_STS: rdata_q <= {26'h0000000, cor_sts_q};
                `PECL_ADDR_ADV_CTL: rdata_q <= {28'h0000000, ptr_q};
                `PECL_ADDR_RP_STS: rdata_q <= {29'h00000000, rp_sts_q};
                `PECL_ADDR_DEV_STS: rdata_q <= {28'h0000000, dev_sts_q};
                `PECL_ADDR_FAT_FIRST: rdata_q <= {19'h00000, fat_first_q};
                `PECL_ADDR_FAT_NEXT: rdata_q <= {19'h00000, fat_next_q};
                `PECL_ADDR_NFC_FIRST: rdata_q <= {13'h0000, nfc_first_q};
                `PECL_ADDR_NFC_NEXT: rdata_q <= {13'h0000, nfc_next_q};
                `PECL_ADDR_HDR_FIRST: rdata_q <= hdr_first_q;
                `PECL_ADDR_HDR_NEXT: rdata_q <= hdr_next_q;
                `PECL_ADDR_HOLD_STS: rdata_q <= {30'h00000000, sg_q, cpu_hold_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign rdata_o = rdata_q;
    assign cpu_hold_o = cpu_hold_q;
    assign fatal_o = fatal_q;
    assign nonfatal_o = nonfatal_q;
    assign corr_o = corr_q;

    // ****************************************
    // Assertions
    // ****************************************
    a_dllp_status_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        dllp_proto_i |=> unc_sts_q[`PECL_BIT_DLLP])
        else $error("DLLP protocol error not in status");

    a_dllp_fatal_route: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (dllp_proto_i && unc_sev_q[`PECL_BIT_DLLP]) |=>
        (fat_first_q[`PECL_BIT_DLLP] || fat_next_q[`PECL_BIT_DLLP]) && fatal_q)
        else $error("Fatal DLLP error not in fatal log");

    a_nonfatal_msg_log: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        msg_nonfatal_i |=> (nfc_first_q[`PECL_BIT_MSG_NF] || nfc_next_q[`PECL_BIT_MSG_NF]) && rp_sts_q[1])
        else $error("Non-fatal message not logged");

    a_bad_tlp_corr: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        bad_tlp_i |=> cor_sts_q[`PECL_COR_BAD_TLP] && corr_q)
        else $error("Bad packet not correctable");

    a_first_log_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (fat_first_q != 13'h0000 && !(wr_i && addr_i == `PECL_ADDR_FAT_FIRST)) |=> $stable(fat_first_q))
        else $error("Fatal first log overwritten");

    a_hold_release: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        tmo_q |-> !cpu_hold_q ##1 unc_sts_q[`PECL_BIT_RST_TMO] && fat_first_q != 13'h0000)
        else $error("Ack timeout did not release hold");

    a_hdr_first_take: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (any_ev && !hdr_first_vld_q) |=> hdr_first_q == $past(hdr_i) && hdr_first_vld_q)
        else $error("First header not captured");

    a_first_ptr_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (unc_sts_q == 13'h0000 && unc_ev == 13'h0004) |=> ptr_q == 4'h2)
        else $error("First error pointer wrong");

    a_link_down_fatal: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        link_down_i |=> fat_first_q[`PECL_BIT_LINK_DOWN] || fat_next_q[`PECL_BIT_LINK_DOWN])
        else $error("Surprise link down not fatal");

    a_dllp_nonfatal: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (dllp_proto_i && !unc_sev_q[`PECL_BIT_DLLP]) |=>
        (nfc_first_q[`PECL_BIT_DLLP] || nfc_next_q[`PECL_BIT_DLLP]) && nonfatal_q)
        else $error("Non-fatal DLLP error not logged");

    a_fatal_msg_log: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        msg_fatal_i |=> (fat_first_q[`PECL_BIT_MSG_FAT] || fat_next_q[`PECL_BIT_MSG_FAT]) && rp_sts_q[2])
        else $error("Fatal message not logged");

    a_unsup_dev_log: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        unsup_req_i |=> unc_sts_q[`PECL_BIT_UNSUP] && dev_sts_q[3])
        else $error("Unsupported request not logged");

    a_replay_tmo_corr: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        replay_timeout_i |=> cor_sts_q[4] && corr_q)
        else $error("Replay timeout not correctable");

    a_corr_msg_root: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        msg_corr_i |=> cor_sts_q[5] && rp_sts_q[0] && corr_q)
        else $error("Correctable message not logged");

    a_hold_raise: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (hold_st_q == pecl_pkg::PECL_HOLD_IDLE && hold_start_i) |=> cpu_hold_q)
        else $error("Processor hold not raised");

    a_ptr_kept: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (unc_sts_q != 13'h0000 && !(wr_i && addr_i == `PECL_ADDR_UNC_STS)) |=> $stable(ptr_q))
        else $error("First error pointer moved");

    a_hdr_next_take: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (any_ev && hdr_first_vld_q) |=> hdr_next_q == $past(hdr_i))
        else $error("Next header not captured");

endmodule : pecl_classifier

// ### core/pecl_pkg.sv
// Types of the link-port error classifier.
// Assumes the constants header is included by the design file.
package pecl_pkg;

    typedef enum logic [0:0] {
        PECL_HOLD_IDLE,
        PECL_HOLD_WAIT
    } pecl_hold_state_t;

endpackage : pecl_pkg

// ### core/pecl_regs.svh
// Constants of the link-port error classifier: offsets, fields, resets, timing.
// Assumes a 100 MHz core clock and a plain strobe register port.
// Operation
// - DLLP protocol error, severity from select bit
// - Fatal message: log fatal, capture header
// - Unsupported request: uncorrectable default, selectable, header
// - Poisoned packet: uncorrectable default, selectable, header
// - Flow control violation: fatal default, selectable
// - Completion timeout: uncorrectable default, selectable
// - Completer abort: uncorrectable default, selectable, header
// - Unexpected completion tag: uncorrectable default, selectable
// - Malformed packet: uncorrectable default, selectable, header
// - Credit overrun: fatal default receive overflow
// - Non-fatal message logged as uncorrectable non-fatal
// - Bad packet CRC or sequence: correctable
// - Bad link packet CRC: correctable
// - Replay count exceeded: correctable rollover
// - Replay timer expiry: correctable timeout
// - Correctable message logged as correctable
// - No reset ack in time: fatal, release hold
// - Surprise link down logged fatal with status
// - Route errors to fatal or non-fatal/correctable logs
// - Record pointer to first uncorrectable status bit
// - Messages in root status; others in device log; messages also set device log bits
// - Capture header of each logged error
`ifndef PECL_REGS_SVH
`define PECL_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PECL_ADDR_UNC_STS 8'h00
`define PECL_ADDR_UNC_SEV 8'h04
`define PECL_ADDR_COR_STS 8'h08
`define PECL_ADDR_ADV_CTL 8'h0C
`define PECL_ADDR_RP_STS 8'h10
`define PECL_ADDR_DEV_STS 8'h14
`define PECL_ADDR_FAT_FIRST 8'h18
`define PECL_ADDR_FAT_NEXT 8'h1C
`define PECL_ADDR_NFC_FIRST 8'h20
`define PECL_ADDR_NFC_NEXT 8'h24
`define PECL_ADDR_HDR_FIRST 8'h28
`define PECL_ADDR_HDR_NEXT 8'h2C
`define PECL_ADDR_HOLD_STS 8'h30

// ****************************************
// Fields and reset values
// ****************************************
`define PECL_UNC_W 13
`define PECL_COR_W 6
`define PECL_NFC_W 19
`define PECL_SEV_RST 13'h0211
`define PECL_SEV_SEL_MASK 13'h03FD
`define PECL_SEV_FIX_FATAL 13'h1802
`define PECL_BIT_DLLP 0
`define PECL_BIT_MSG_FAT 1
`define PECL_BIT_UNSUP 2
`define PECL_BIT_MSG_NF 10
`define PECL_BIT_RST_TMO 11
`define PECL_BIT_LINK_DOWN 12
`define PECL_COR_BAD_TLP 1

// ****************************************
// Timing
// ****************************************
`define PECL_CLK_NS 10
`define PECL_ACK_WAIT_NS 1000000

`endif

// ### tb/pcie_port_error_classifier_tb.sv
// Bench of the link-port error classifier: register port, event lines, processor hold.
// Assumes the south bridge model drives all event lines, the header and the acknowledge.
`include "pecl_regs.svh"

module pcie_port_error_classifier_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ACK_WAIT = 8;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic supply_good_i = 1'b0;
    logic hold_start_i = 1'b0;
    logic [17:0] req = '0;
    logic [31:0] req_hdr = 32'h0;
    logic [7:0] ack_dly = 8'h00;
    logic [31:0] rdata_o, hdr, sev, h, d, nf, nn, nc, hn;
    logic [17:0] ev;
    logic cpu_hold_o, fatal_o, nonfatal_o, corr_o, ack;
    int errors = 0;
    int total_checks = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    pecl_classifier #(.ACK_WAIT_CYC(ACK_WAIT)) uut (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .dllp_proto_i(ev[0]), .msg_fatal_i(ev[1]),
        .unsup_req_i(ev[2]), .poisoned_i(ev[3]), .fc_proto_i(ev[4]), .cpl_timeout_i(ev[5]),
        .cpl_abort_i(ev[6]), .unexp_cpl_i(ev[7]), .malformed_i(ev[8]), .rx_overflow_i(ev[9]),
        .msg_nonfatal_i(ev[10]), .link_down_i(ev[11]), .receiver_err_i(ev[12]), .bad_tlp_i(ev[13]),
        .bad_dllp_i(ev[14]), .replay_rollover_i(ev[15]), .replay_timeout_i(ev[16]),
        .msg_corr_i(ev[17]), .hdr_i(hdr), .supply_good_i(supply_good_i),
        .hold_start_i(hold_start_i), .reset_done_ack_i(ack), .cpu_hold_o(cpu_hold_o),
        .fatal_o(fatal_o), .nonfatal_o(nonfatal_o), .corr_o(corr_o)
    );

    pecl_sb_model far (
        .clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_i(req), .req_hdr_i(req_hdr),
        .hold_i(cpu_hold_o), .ack_dly_i(ack_dly), .ev_o(ev), .hdr_o(hdr), .ack_o(ack)
    );

    // ****************************************
    // Compare, bus and event tasks
    // ****************************************
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask : rd_reg

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd_reg(a, v);
        chk_word(v, e);
    endtask : chk_reg

    task automatic clear_all();
        for (int a = 0; a < 48; a += 4) begin
            if (a != 4) wr_reg(8'(a), 32'hFFFFFFFF);
        end
    endtask : clear_all

    task automatic watch();
        nf = 32'h0;
        nn = 32'h0;
        nc = 32'h0;
        repeat (4) begin
            @(posedge ref_clk_i);
            #1;
            nf += 32'(fatal_o === 1'b1);
            nn += 32'(nonfatal_o === 1'b1);
            nc += 32'(corr_o === 1'b1);
        end
    endtask : watch

    task automatic fire(input int i, input logic [31:0] hv);
        @(posedge ref_clk_i);
        req <= 18'h00001 << i;
        req_hdr <= hv;
        @(posedge ref_clk_i);
        req <= '0;
        watch();
    endtask : fire

    task automatic hold_run();
        @(posedge ref_clk_i);
        hold_start_i <= 1'b1;
        @(posedge ref_clk_i);
        hold_start_i <= 1'b0;
        hn = 32'h0;
        #1;
        while (cpu_hold_o === 1'b1 && hn < 60) begin
            @(posedge ref_clk_i);
            #1;
            hn++;
        end
    endtask : hold_run

    function automatic logic is_fatal(input int ub, input logic [31:0] s);
        logic [12:0] sel;
        sel = (s[12:0] & `PECL_SEV_SEL_MASK) | `PECL_SEV_FIX_FATAL;
        return sel[ub];
    endfunction : is_fatal

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(25136));
        repeat (12) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        supply_good_i <= 1'b1;
        chk_reg(`PECL_ADDR_UNC_SEV, {19'h0, `PECL_SEV_RST});
        chk_reg(`PECL_ADDR_UNC_STS, 32'h0);
        chk_reg(8'hFC, 32'h0);
        sev = $urandom();
        wr_reg(`PECL_ADDR_UNC_SEV, sev);
        rd_reg(`PECL_ADDR_UNC_SEV, d);
        chk_word(d & {19'h0, `PECL_SEV_SEL_MASK}, sev & {19'h0, `PECL_SEV_SEL_MASK});
        $display("test reset done");
        for (int i = 0; i < 18; i++) begin
            int ub;
            logic fat;
            logic cr;
            sev = $urandom();
            h = $urandom();
            clear_all();
            chk_reg(`PECL_ADDR_UNC_STS, 32'h0);
            wr_reg(`PECL_ADDR_UNC_SEV, sev);
            cr = (i >= 12);
            ub = (i == 11) ? 12 : i;
            fat = !cr && is_fatal(ub, sev);
            fire(i, h);
            chk_word(nf, 32'(fat));
            chk_word(nn, 32'(!cr && !fat));
            chk_word(nc, 32'(cr));
            chk_reg(`PECL_ADDR_UNC_STS, cr ? 32'h0 : 32'h1 << ub);
            chk_reg(`PECL_ADDR_COR_STS, cr ? 32'h1 << (i - 12) : 32'h0);
            chk_reg(`PECL_ADDR_FAT_FIRST, fat ? 32'h1 << ub : 32'h0);
            chk_reg(`PECL_ADDR_NFC_FIRST, fat ? 32'h0 : 32'h1 << (cr ? i + 1 : ub));
            chk_reg(`PECL_ADDR_HDR_FIRST, h);
            chk_reg(`PECL_ADDR_RP_STS, i == 1 ? 32'h4 : i == 10 ? 32'h2 : i == 17 ? 32'h1 : 32'h0);
            chk_reg(`PECL_ADDR_DEV_STS, (i == 2 ? 32'h8 : 32'h0) | (fat ? 32'h4 : cr ? 32'h1 : 32'h2));
            if (!cr) begin
                rd_reg(`PECL_ADDR_ADV_CTL, d);
                chk_word(d & 32'h0000000F, 32'(ub));
            end
        end
        $display("test events done");
        clear_all();
        wr_reg(`PECL_ADDR_UNC_SEV, 32'h0);
        h = $urandom();
        fire(8, h);
        fire(3, ~h);
        chk_reg(`PECL_ADDR_NFC_FIRST, 32'h00000100);
        chk_reg(`PECL_ADDR_NFC_NEXT, 32'h00000008);
        chk_reg(`PECL_ADDR_HDR_FIRST, h);
        chk_reg(`PECL_ADDR_HDR_NEXT, ~h);
        chk_reg(`PECL_ADDR_UNC_STS, 32'h00000108);
        wr_reg(`PECL_ADDR_ADV_CTL, 32'h00000000);
        rd_reg(`PECL_ADDR_ADV_CTL, d);
        chk_word(d & 32'h0000000F, 32'h8);
        $display("test first next done");
        clear_all();
        ack_dly <= 8'h03;
        hold_run();
        chk_word(32'(hn > 0 && hn < ACK_WAIT), 32'h1);
        chk_reg(`PECL_ADDR_UNC_STS, 32'h0);
        ack_dly <= 8'h00;
        hold_run();
        chk_word(32'(hn >= ACK_WAIT && hn <= ACK_WAIT + 2), 32'h1);
        watch();
        chk_word(nf, 32'h1);
        chk_reg(`PECL_ADDR_UNC_STS, 32'h00000800);
        clear_all();
        supply_good_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        hold_run();
        chk_word(hn, 32'd60);
        chk_reg(`PECL_ADDR_HOLD_STS, 32'h1);
        chk_reg(`PECL_ADDR_UNC_STS, 32'h0);
        supply_good_i <= 1'b1;
        hold_run();
        chk_word(32'(hn <= ACK_WAIT + 6), 32'h1);
        chk_reg(`PECL_ADDR_UNC_STS, 32'h00000800);
        chk_reg(`PECL_ADDR_HOLD_STS, 32'h2);
        $display("test hold done");
        give_verdict();
    end

    initial begin
        #200000;
        errors++;
        $display("timeout at %0t", $time);
        give_verdict();
    end
endmodule : pcie_port_error_classifier_tb

// ### tb/pecl_sb_model.sv
// South bridge side model: error event lines, packet header, reset-done acknowledge.
// Assumes the bench requests events one cycle ahead on the core clock.
module pecl_sb_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [17:0] req_i,
    input wire logic [31:0] req_hdr_i,
    input wire logic hold_i,
    input wire logic [7:0] ack_dly_i,
    output logic [17:0] ev_o,
    output logic [31:0] hdr_o,
    output logic ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    // ****************************************
    // Event lines and header
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ev_o <= '0;
            hdr_o <= '0;
        end else begin
            ev_o <= req_i;
            hdr_o <= (|req_i) ? req_hdr_i : ~hdr_o;
        end
    end
    // ****************************************
    // Reset-done acknowledge, never if delay is 0
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= 8'h00;
            ack_o <= 1'b0;
        end else begin
            cnt_q <= hold_i ? cnt_q + 8'h01 : 8'h00;
            ack_o <= hold_i && ack_dly_i != 8'h00 && cnt_q == ack_dly_i;
        end
    end
endmodule : pecl_sb_model
